// ### src/upsme_pkg.sv
// Constants, register map and types of the serial message engine
package upsme_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CHARS = 8'h04;
   localparam logic [7:0] A_TIMES = 8'h08;
   localparam logic [7:0] A_BAUD = 8'h0C;
   localparam logic [7:0] A_CMD = 8'h10;
   localparam logic [7:0] A_TXBUF = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_RXBUF = 8'h1C;
   // ****************************************
   // Control and command word fields
   // ****************************************
   localparam int CB_EN = 7;
   localparam int CB_SC = 6;
   localparam int CB_EC = 5;
   localparam int CB_IL = 4;
   localparam int CB_CM = 3;
   localparam int CB_TMR = 2;
   localparam int CB_PAR = 8;
   localparam int CB_ODD = 9;
   localparam int CMD_RX = 0;
   localparam int CMD_TX = 1;
   // ****************************************
   // Receive status byte fields
   // ****************************************
   localparam int ST_N = 7;
   localparam int ST_R = 6;
   localparam int ST_E = 5;
   localparam int ST_T = 2;
   localparam int ST_C = 1;
   localparam int ST_P = 0;
   localparam logic [7:0] ST_RESET = 8'h80;
   localparam logic [7:0] ST_MASK = 8'hE7;
   // ****************************************
   // Reset values, events, timing
   // ****************************************
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [15:0] BAUD_RESET = 16'h0A2C;
   localparam logic [4:0] EVT_TX0 = 5'h09;
   localparam logic [4:0] EVT_TX1 = 5'h1A;
   localparam logic [4:0] EVT_RX0 = 5'h17;
   localparam logic [4:0] EVT_RX1 = 5'h18;
   localparam logic [4:0] BREAK_BITS = 5'h10;
   localparam logic [3:0] FRAME_BITS = 4'hA;
   localparam int BUF_DEPTH = 256;
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 40;
   localparam int MS_CYC_DEF = MS_NS / CLK_NS;
   typedef enum logic [1:0] {T_IDLE, T_LOAD, T_SEND, T_BREAK} upsme_tx_t;
   typedef enum logic [1:0] {R_IDLE, R_WIDLE, R_WSTART, R_RUN} upsme_rx_t;
endpackage

// ### src/upsme_top.sv
// One port of the user-programmed serial message engine, AHB-Lite slave
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - Transmit done raises event 9 or 26
// R02 - Pollable transmit idle flag per port
// R03 - Zero count transmit sends a break
// R04 - Break lasts sixteen bit periods
// R05 - Break ends like a normal message
// R06 - Receive one to 255 characters
// R07 - Receive done raises event 23 or 24
// R08 - Status zero while receiving, else nonzero
// R09 - Parity error ends receive
// R10 - Software sets start and end conditions
// R11 - Bit 7: ended by disable command
// R12 - Bit 6: bad parameters or conditions
// R13 - Bit 5: end character received
// R14 - Bits 4 and 3 read zero
// R15 - Bit 2: timer expired
// R16 - Bit 1: maximum count reached
// R17 - Bit 0: parity error
// R18 - Maximum count 1 to 255, always set
// R19 - Message or inter-character timeout ends receive
// R20 - Idle start restarts timer per character
// R21 - Exactly one stop bit per character
// R22 - First buffer byte is count, ascending
// R23 - New receive clears status first
module upsme_top
   import upsme_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC_DEF,
   parameter bit PORT_SEL = 1'b0
)
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic TXD,
   input wire logic RXD,
   output logic TX_IDLE,
   output logic TX_DONE_EVT,
   output logic RX_DONE_EVT,
   output logic [4:0] TX_EVT_NUM,
   output logic [4:0] RX_EVT_NUM,
   output logic [7:0] RX_STATUS
);
   // ****************************************
   // Bus slave
   // ****************************************
   logic dp_wr;
   logic [7:0] dp_addr;
   logic [31:0] hrdata;
   logic [9:0] ctrl;
   logic [23:0] chars;
   logic [31:0] times;
   logic [15:0] baud;
   logic [7:0] rx_status;
   logic [7:0] rx_cnt;
   logic [7:0] rd_idx;
   logic [7:0] rx_mem [BUF_DEPTH];
   logic [7:0] tx_mem [BUF_DEPTH];
   logic [7:0] tx_wp;
   upsme_tx_t tx_st;
   upsme_rx_t rx_st;
   wire acc = HSEL & HREADY & HTRANS[1];
   wire rd_take = acc & ~HWRITE;
   wire [7:0] ra = HADDR[7:0];
   wire w_ctrl = dp_wr & (dp_addr == A_CTRL);
   wire w_chars = dp_wr & (dp_addr == A_CHARS);
   wire w_times = dp_wr & (dp_addr == A_TIMES);
   wire w_baud = dp_wr & (dp_addr == A_BAUD);
   wire w_cmd = dp_wr & (dp_addr == A_CMD);
   wire w_txb = dp_wr & (dp_addr == A_TXBUF) & (tx_st == T_IDLE);
   wire cmd_rx = w_cmd & HWDATA[CMD_RX];
   wire cmd_tx = w_cmd & HWDATA[CMD_TX] & (tx_st == T_IDLE);
   wire rd_rxb = rd_take & (ra == A_RXBUF);
   wire [7:0] rxb_val = (rd_idx == 8'h00) ? rx_cnt : rx_mem[rd_idx]; // R22
   wire [31:0] stat_val = {8'h00, rx_cnt, 7'h00, TX_IDLE, rx_status & ST_MASK}; // R14
   wire [31:0] rd_mux =
      (ra == A_CTRL) ? {22'h0, ctrl} :
      (ra == A_CHARS) ? {8'h00, chars} :
      (ra == A_TIMES) ? times :
      (ra == A_BAUD) ? {16'h0, baud} :
      (ra == A_STAT) ? stat_val :
      (ra == A_RXBUF) ? {24'h0, rxb_val} : 32'h0;
   wire [7:0] start_ch = chars[7:0];
   wire [7:0] end_ch = chars[15:8];
   wire [7:0] max_cnt = chars[23:16];
   wire [15:0] idle_ms = times[15:0];
   wire [15:0] tmo_ms = times[31:16];
   wire [15:0] baud_last = baud - 16'h0001;
   wire par_en = ctrl[CB_PAR];
   wire odd = ctrl[CB_ODD];
   // Zero wait state: every transfer completes in its data phase
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata;
   assign TX_EVT_NUM = PORT_SEL ? EVT_TX1 : EVT_TX0; // R01
   assign RX_EVT_NUM = PORT_SEL ? EVT_RX1 : EVT_RX0; // R07
   assign RX_STATUS = rx_status & ST_MASK; // R08
   assign TX_IDLE = (tx_st == T_IDLE); // R02

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h0;
      end
      else
      begin
         dp_wr <= acc & HWRITE;
         dp_addr <= acc ? ra : dp_addr;
         hrdata <= rd_take ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ctrl <= CTRL_RESET;
         chars <= 24'h0;
         times <= 32'h0;
         baud <= BAUD_RESET;
      end
      else
      begin
         if (w_ctrl)
            ctrl <= HWDATA[9:0];
         if (w_chars)
            chars <= HWDATA[23:0];
         if (w_times)
            times <= HWDATA;
         if (w_baud)
            baud <= HWDATA[15:0];
      end
   end

   // ****************************************
   // Transmit buffer and transmitter
   // ****************************************
   logic [10:0] tsh;
   logic [3:0] tbits;
   logic [4:0] bk_bits;
   logic [15:0] tbaud;
   logic [8:0] tx_idx;
   logic [7:0] tx_cnt;
   logic tx_done;
   wire [7:0] tx_ch = tx_mem[tx_idx[7:0]];
   wire tbit_end = (tbaud == baud_last);
   // One stop bit; the spare top bit idles high when parity is off
   wire [10:0] frame = par_en ? {1'b1, ^tx_ch ^ odd, tx_ch, 1'b0}
                              : {2'b11, tx_ch, 1'b0}; // R21
   wire [3:0] nbits = FRAME_BITS + {3'h0, par_en};
   assign TXD = tsh[0];
   assign TX_DONE_EVT = tx_done;

   always_ff @(posedge CORE_CLK)
   begin
      if (w_txb)
         tx_mem[tx_wp] <= HWDATA[7:0];
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         tx_wp <= 8'h00;
      else if (cmd_tx)
         tx_wp <= 8'h00;
      else if (w_txb)
         tx_wp <= tx_wp + 8'h01; // R22
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         tx_st <= T_IDLE;
         tsh <= 11'h7FF;
         tbits <= 4'h0;
         bk_bits <= 5'h00;
         tbaud <= 16'h0;
         tx_idx <= 9'h000;
         tx_cnt <= 8'h00;
         tx_done <= 1'b0;
      end
      else
      begin
         tx_done <= 1'b0;
         unique case (tx_st)
            T_IDLE:
               if (cmd_tx)
               begin
                  tx_cnt <= tx_mem[0]; // R22
                  tx_idx <= 9'h001;
                  tbaud <= 16'h0;
                  bk_bits <= 5'h00;
                  if (tx_mem[0] == 8'h00)
                  begin
                     tsh <= 11'h000; // R03
                     tx_st <= T_BREAK;
                  end
                  else
                     tx_st <= T_LOAD;
               end
            T_LOAD:
            begin
               tsh <= frame;
               tbits <= 4'h0;
               tbaud <= 16'h0;
               tx_idx <= tx_idx + 9'h001; // R22
               tx_st <= T_SEND;
            end
            T_SEND:
               if (tbit_end)
               begin
                  tbaud <= 16'h0;
                  tsh <= {1'b1, tsh[10:1]};
                  tbits <= tbits + 4'h1;
                  if (tbits == nbits - 4'h1)
                  begin
                     tsh <= 11'h7FF;
                     if (tx_idx > {1'b0, tx_cnt})
                     begin
                        tx_done <= 1'b1; // R01
                        tx_st <= T_IDLE;
                     end
                     else
                        tx_st <= T_LOAD;
                  end
               end
               else
                  tbaud <= tbaud + 16'h0001;
            T_BREAK:
               if (tbit_end)
               begin
                  tbaud <= 16'h0;
                  bk_bits <= bk_bits + 5'h01;
                  if (bk_bits == BREAK_BITS - 5'h01) // R04
                  begin
                     tsh <= 11'h7FF;
                     tx_done <= 1'b1; // R05
                     tx_st <= T_IDLE;
                  end
               end
               else
                  tbaud <= tbaud + 16'h0001;
         endcase
      end
   end

   // ****************************************
   // Receiver character framing
   // ****************************************
   logic rx_s1;
   logic rx_s2;
   logic rx_q;
   logic rbusy;
   logic [3:0] rbitn;
   logic [15:0] rbaud;
   logic [7:0] rsh;
   logic rpar;
   logic char_v;
   logic char_pe;
   wire rbit_end = (rbaud == 16'h0);
   wire r_last = (rbitn == nbits - 4'h1);
   wire r_data = (rbitn != 4'h0) & ~r_last & ~(par_en & (rbitn == nbits - 4'h2));

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_q <= 1'b1;
      end
      else
      begin
         rx_s1 <= RXD;
         rx_s2 <= rx_s1;
         rx_q <= rx_s2;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rbusy <= 1'b0;
         rbitn <= 4'h0;
         rbaud <= 16'h0;
         rsh <= 8'h00;
         rpar <= 1'b0;
         char_v <= 1'b0;
         char_pe <= 1'b0;
      end
      else
      begin
         char_v <= 1'b0;
         if (!rbusy)
         begin
            // Falling edge, then wait half a bit to sample mid-bit
            if (rx_q & ~rx_s2)
            begin
               rbusy <= 1'b1;
               rbitn <= 4'h0;
               rpar <= odd;
               rbaud <= {1'b0, baud_last[15:1]};
            end
         end
         else if (!rbit_end)
            rbaud <= rbaud - 16'h0001;
         else
         begin
            rbaud <= baud_last;
            rbitn <= rbitn + 4'h1;
            if (rbitn == 4'h0)
               rbusy <= ~rx_s2;
            else if (r_last)
            begin
               rbusy <= 1'b0;
               char_v <= 1'b1;
               char_pe <= par_en & rpar; // R17
            end
            else
            begin
               rpar <= rpar ^ rx_s2;
               if (r_data)
                  rsh <= {rx_s2, rsh[7:1]};
            end
         end
      end
   end

   // ****************************************
   // Receive message control
   // ****************************************
   logic [15:0] pre;
   logic [15:0] ms_cnt;
   logic rx_done;
   wire start_ok = ~ctrl[CB_SC] | (rsh == start_ch);
   wire store = char_v & ~char_pe
                & ((rx_st == R_RUN) | ((rx_st == R_WSTART) & start_ok));
   wire [7:0] next_cnt = rx_cnt + 8'h01;
   wire hit_end = ctrl[CB_EC] & (rsh == end_ch); // R13
   wire hit_max = (next_cnt == max_cnt); // R16
   wire rx_act = (rx_st != R_IDLE);
   wire rx_go = cmd_rx & ctrl[CB_EN];
   // A character still arriving means the line is not quiet yet
   wire idle_exp = (rx_st == R_WIDLE) & (ms_cnt >= idle_ms) & ~rbusy; // R20
   wire tmo_exp = (rx_st == R_RUN) & ctrl[CB_TMR] & (ms_cnt > tmo_ms); // R19
   wire tmr_clr = rx_go | (rx_st == R_WIDLE) & (char_v | idle_exp)
                  | store & (~ctrl[CB_CM] | (rx_st == R_WSTART)); // R20
   assign RX_DONE_EVT = rx_done;

   // Millisecond timer shared by the idle-line and receive timeouts
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pre <= 16'h0;
         ms_cnt <= 16'h0;
      end
      else if (tmr_clr)
      begin
         pre <= 16'h0;
         ms_cnt <= 16'h0;
      end
      else if (pre == 16'(MS_CYCLES - 1))
      begin
         pre <= 16'h0;
         ms_cnt <= (ms_cnt == 16'hFFFF) ? ms_cnt : ms_cnt + 16'h0001;
      end
      else
         pre <= pre + 16'h0001;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (store)
         rx_mem[next_cnt] <= rsh; // R06
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         rd_idx <= 8'h00;
      else if (rx_go)
         rd_idx <= 8'h00;
      else if (rd_rxb)
         rd_idx <= rd_idx + 8'h01;
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rx_st <= R_IDLE;
         rx_status <= ST_RESET; // R08
         rx_cnt <= 8'h00;
         rx_done <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         if (cmd_rx & ~ctrl[CB_EN])
         begin
            if (rx_act)
               rx_status <= 8'h01 << ST_N; // R11
            rx_st <= R_IDLE;
         end
         else if (rx_go)
         begin
            rx_cnt <= 8'h00;
            if (max_cnt == 8'h00) // R18
            begin
               rx_status <= 8'h01 << ST_R; // R12
               rx_st <= R_IDLE;
            end
            else
            begin
               rx_status <= 8'h00; // R23
               rx_st <= ctrl[CB_IL] ? R_WIDLE : R_WSTART;
            end
         end
         else if (rx_act & char_v & char_pe)
         begin
            rx_status <= 8'h01 << ST_P; // R09
            rx_done <= 1'b1;
            rx_st <= R_IDLE;
         end
         else if (store)
         begin
            rx_cnt <= next_cnt;
            rx_st <= R_RUN;
            if (hit_end | hit_max)
            begin
               rx_status <= hit_end ? 8'h01 << ST_E : 8'h01 << ST_C;
               rx_done <= 1'b1; // R07
               rx_st <= R_IDLE;
            end
         end
         else if (tmo_exp)
         begin
            rx_status <= 8'h01 << ST_T; // R15
            rx_done <= 1'b1;
            rx_st <= R_IDLE;
         end
         else if (idle_exp)
            rx_st <= R_WSTART;
      end
   end
endmodule
`default_nettype wire

// ### test/upsme_top_props.sv
// Concurrent checks on the ports of one serial message engine port
`timescale 1ns/1ps
`default_nettype none
module upsme_top_props
   import upsme_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC_DEF,
   parameter bit PORT_SEL = 1'b0
)
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic TXD,
   input wire logic TX_IDLE,
   input wire logic TX_DONE_EVT,
   input wire logic RX_DONE_EVT,
   input wire logic [4:0] TX_EVT_NUM,
   input wire logic [4:0] RX_EVT_NUM,
   input wire logic [7:0] RX_STATUS
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   property p_tx_evt_num;
      TX_EVT_NUM == (PORT_SEL ? EVT_TX1 : EVT_TX0);
   endproperty
   a_tx_evt_num: assert property (p_tx_evt_num)
      else $error("transmit event number wrong");
   property p_rx_evt_num;
      RX_EVT_NUM == (PORT_SEL ? EVT_RX1 : EVT_RX0);
   endproperty
   a_rx_evt_num: assert property (p_rx_evt_num)
      else $error("receive event number wrong");
   property p_done_pulse;
      TX_DONE_EVT |=> !TX_DONE_EVT;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("transmit done longer than one cycle");
   property p_done_idle;
      TX_DONE_EVT |-> TX_IDLE && !$past(TX_IDLE);
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("transmit done without idle change");
   property p_idle_rose;
      $rose(TX_IDLE) |-> TX_DONE_EVT;
   endproperty
   a_idle_rose: assert property (p_idle_rose)
      else $error("transmitter went idle without done");
   property p_txd_idle_high;
      TX_IDLE |-> TXD;
   endproperty
   a_txd_idle_high: assert property (p_txd_idle_high)
      else $error("line not high while idle");
   property p_stat_zero_bits;
      RX_STATUS[4:3] == 2'b00;
   endproperty
   a_stat_zero_bits: assert property (p_stat_zero_bits)
      else $error("reserved status bits set");
   property p_rx_done_cause;
      RX_DONE_EVT |-> ##[0:1] ($onehot(RX_STATUS) && RX_STATUS[7:6] == 2'b00);
   endproperty
   a_rx_done_cause: assert property (p_rx_done_cause)
      else $error("receive done with bad cause");
   property p_rx_done_nonzero;
      RX_DONE_EVT |=> (RX_STATUS != 8'h00) [*2];
   endproperty
   a_rx_done_nonzero: assert property (p_rx_done_nonzero)
      else $error("status zero after receive end");
   property p_bus_okay;
      HREADYOUT && !HRESP;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus wait or error response");
endmodule
bind upsme_top upsme_top_props #(.MS_CYCLES(MS_CYCLES), .PORT_SEL(PORT_SEL)) i_upsme_top_props (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .TXD(TXD), .TX_IDLE(TX_IDLE), .TX_DONE_EVT(TX_DONE_EVT), .RX_DONE_EVT(RX_DONE_EVT),
   .TX_EVT_NUM(TX_EVT_NUM), .RX_EVT_NUM(RX_EVT_NUM), .RX_STATUS(RX_STATUS));
`default_nettype wire

// ### test/upsme_serial_dev.sv
// Behavioural far-end serial device: sends frames, decodes frames
`timescale 1ns/1ps
`default_nettype none
module upsme_serial_dev #(
   parameter int BIT_CYC = 8
)
(
   input wire logic clk,
   output logic rxd,
   input wire logic txd
);
   logic [7:0] got[$];
   int stop_err = 0;
   logic [7:0] sh;
   initial rxd = 1'b1;
   // Parity mode: 0 none, 1 even and correct, 2 even and wrong
   task automatic send_char(input logic [7:0] b, input int par);
      logic [10:0] fr;
      int n;
      fr = {1'b1, (par == 2) ? ~(^b) : ^b, b, 1'b0};
      n = (par == 0) ? 10 : 11;
      if (par == 0)
      begin
         fr[9] = 1'b1;
      end
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         rxd <= fr[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask
   // ****************************************
   // Frame decoder, a frame with all-zero data and low stop is a break
   // ****************************************
   initial
   begin
      forever
      begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = txd;
         end
         repeat (BIT_CYC) @(posedge clk);
         if (txd === 1'b1)
         begin
            got.push_back(sh);
         end
         else if (sh !== 8'h00)
         begin
            stop_err++;
         end
         if (txd !== 1'b1)
         begin
            @(posedge txd);
         end
      end
   end
endmodule
`default_nettype wire

// ### test/user_protocol_serial_msg_engine_bench.sv
// Self-checking bench of one serial message engine port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module user_protocol_serial_msg_engine_bench
   import upsme_pkg::*;
;
   localparam int BAUD = 8;
   logic clk, rst_n, hsel, hwrite, rxd;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, txd, tx_idle, tx_done, rx_done;
   logic [7:0] rx_status;
   int bad_count = 0;
   int n_tests = 0;
   int lows;
   upsme_top #(.MS_CYCLES(20), .PORT_SEL(1'b0)) i_upsme_top (
      .CORE_CLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .TXD(txd), .RXD(rxd), .TX_IDLE(tx_idle),
      .TX_DONE_EVT(tx_done), .RX_DONE_EVT(rx_done), .TX_EVT_NUM(), .RX_EVT_NUM(),
      .RX_STATUS(rx_status));
   upsme_serial_dev #(.BIT_CYC(BAUD)) i_upsme_serial_dev (.clk(clk), .rxd(rxd), .txd(txd));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************************************
   // Bus tasks, single word transfers
   // ****************************************
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rdv(input logic [7:0] a);
      bus(a, 1'b0, 32'h00000000);
   endtask
   // Bounded wait on a done pulse, counting low line cycles meanwhile
   task automatic wait_evt(input logic rx);
      int k;
      lows = 0;
      for (k = 0; k < 5000; k++)
      begin
         @(posedge clk);
         lows += (txd === 1'b0);
         if ((rx ? rx_done : tx_done) === 1'b1)
         begin
            break;
         end
      end
      `CHK(k < 5000, 1'b1)
   endtask
   // Start a receive, feed characters, expect the final status byte
   task automatic rx_case(input logic [31:0] ctrl, input logic [31:0] chars,
                          input logic [7:0] c0, input logic [7:0] c1, input int n, input int par,
                          input logic [7:0] st);
      wr(A_CTRL, ctrl);
      wr(A_CHARS, chars);
      wr(A_CMD, 32'h00000001);
      rdv(A_STAT);
      `CHK(rd[7:0], 8'h00)
      // A receive expected to stay open raises no done pulse to wait for
      fork
         if (st != 8'h00) wait_evt(1'b1);
         begin
            if (n > 0) i_upsme_serial_dev.send_char(c0, par);
            if (n > 1) i_upsme_serial_dev.send_char(c1, par);
         end
      join
      rdv(A_STAT);
      `CHK(rd[7:0], st)
   endtask
   task automatic print_verdict();
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdv(A_STAT);
      `CHK(rd[8:0], 9'h180)
      rdv(A_BAUD);
      `CHK(rd, 32'h00000A2C)
      rdv(8'h20);
      `CHK(rd, 32'h00000000)
      wr(A_BAUD, BAUD);
      // Counted transmit, count byte first
      wr(A_TXBUF, 32'h00000002);
      wr(A_TXBUF, 32'h00000055);
      wr(A_TXBUF, 32'h000000A3);
      wr(A_CMD, 32'h00000002);
      wait_evt(1'b0);
      repeat (2 * BAUD) @(posedge clk);
      `CHK(i_upsme_serial_dev.got.size(), 2)
      `CHK(i_upsme_serial_dev.got[0], 8'h55)
      `CHK(i_upsme_serial_dev.got[1], 8'hA3)
      rdv(A_STAT);
      `CHK(rd[8], 1'b1)
      // Zero count gives a break of sixteen bit times
      wr(A_TXBUF, 32'h00000000);
      wr(A_CMD, 32'h00000002);
      wait_evt(1'b0);
      `CHK(lows, 16 * BAUD)
      `CHK(i_upsme_serial_dev.stop_err, 0)
      // Maximum count end, then read back buffer
      rx_case(32'h80, 32'h00030000, 8'h31, 8'h32, 2, 0, 8'h00);
      fork
         wait_evt(1'b1);
         i_upsme_serial_dev.send_char(8'h33, 0);
      join
      rdv(A_STAT);
      `CHK(rd[23:0], 24'h030102)
      for (int i = 0; i < 4; i++)
      begin
         rdv(A_RXBUF);
         `CHK(rd[7:0], (i == 0) ? 8'h03 : 8'h30 + i[7:0])
      end
      rx_case(32'hA0, 32'h000A0D00, 8'h41, 8'h0D, 2, 0, 8'h20);
      rx_case(32'h180, 32'h000A0000, 8'h5A, 8'h00, 1, 2, 8'h01);
      wr(A_TIMES, 32'h00020000);
      rx_case(32'h84, 32'h000A0000, 8'h66, 8'h00, 1, 0, 8'h04);
      `CHK(rd[23:16], 8'h01)
      // Zero maximum count is refused
      wr(A_CHARS, 32'h00000000);
      wr(A_CTRL, 32'h00000080);
      wr(A_CMD, 32'h00000001);
      repeat (3) @(posedge clk);
      rdv(A_STAT);
      `CHK(rd[7:0], 8'h40)
      // Disable in mid receive
      wr(A_CHARS, 32'h00050000);
      wr(A_CMD, 32'h00000001);
      wr(A_CTRL, 32'h00000000);
      wr(A_CMD, 32'h00000001);
      repeat (2) @(posedge clk);
      rdv(A_STAT);
      `CHK(rd[7:0], 8'h80)
      print_verdict();
   end
endmodule
`default_nettype wire
